// ### include/pmi_pkg.sv
// Shared constants and types for the two-wire PMBus slave interface
package pmi_pkg;

  // ==========================================================================
  // Strap sensing codes, one per strap connection (GND, rail, SDA, SCL)
  localparam logic [1:0] STRAP_GND  = 2'h0;
  localparam logic [1:0] STRAP_RAIL = 2'h1;
  localparam logic [1:0] STRAP_SDA  = 2'h2;
  localparam logic [1:0] STRAP_SCL  = 2'h3;

  // ==========================================================================
  // Addressing and byte decoding
  localparam logic       ADDR_LEAD    = 1'h1;
  localparam logic [4:0] MCODE_PREFIX = 5'h01;
  localparam logic       DIR_READ     = 1'h1;
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam logic [7:0] PTR_STEP     = 8'h01;

  // ==========================================================================
  // Bit slot positions within one byte frame
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  localparam logic [3:0] ACK_DONE = 4'hA;

  // ==========================================================================
  // Data bytes per write
  localparam logic [1:0] WCNT_HI   = 2'h0;
  localparam logic [1:0] WCNT_LO   = 2'h1;
  localparam logic [1:0] WCNT_FULL = 2'h2;

  // ==========================================================================
  // Power-up quiet time
  localparam int CLK_FREQ_MHZ = 40;
  localparam int PU_TIME_NS   = 1000;
  localparam int PU_CYCLES    = (PU_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int PU_CNT_W     = $clog2(PU_CYCLES + 1);

  // ==========================================================================
  // Protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REG,
    ST_DATA,
    ST_TX,
    ST_SKIP
  } pmi_state_t;

endpackage : pmi_pkg

// ### core/pmi_sync.sv
// Two-flop synchroniser for a bundle of level signals
`timescale 1ns/1ps
`default_nettype none
module pmi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Foreign levels in, local levels out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pmi_sync_t;

  pmi_sync_t r;
  pmi_sync_t next_r;

  // ==========================================================================
  // First stage feeds only the second
  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule : pmi_sync
`default_nettype wire

// ### core/pmi_scl_capture.sv
// Link-clock side: samples SDA on each rising SCL and flags it by a toggle
`timescale 1ns/1ps
`default_nettype none
module pmi_scl_capture (
  // Link clock and system reset
  input  wire logic link_scl,
  input  wire logic rst,
  // Serial data pin
  input  wire logic sda_in,
  // Sampled bit and its event toggle
  output logic      bit_val,
  output logic      bit_tgl
);

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic bit_val;
    logic bit_tgl;
  } pmi_cap_t;

  pmi_cap_t r;
  pmi_cap_t next_r;

  // ==========================================================================
  // Bit stays stable a whole SCL period, so the toggle qualifies it
  always_comb begin
    next_r        = r;
    next_r.rst_s1 = rst;
    next_r.rst_s2 = r.rst_s1;
    if (r.rst_s2) begin
      next_r.bit_val = 1'h0;
      next_r.bit_tgl = 1'h0;
    end else begin
      next_r.bit_val = sda_in;   // see [RQ2]
      next_r.bit_tgl = ~r.bit_tgl;
    end
  end

  always_ff @(posedge link_scl) begin
    r <= next_r;
  end

  assign bit_val = r.bit_val;
  assign bit_tgl = r.bit_tgl;

endmodule : pmi_scl_capture
`default_nettype wire

// ### core/pmi_slave.sv
// Two-wire PMBus/SMBus slave: framing, addressing, two-byte reads and writes
//
// Operation
// [RQ1] Acts only as slave; master starts every transfer and drives SCL.
// [RQ2] Every read and write carries two data bytes, MSB first.
// [RQ3] SDA changes only while SCL low; high-phase edges are START or STOP.
// [RQ4] After power-up the SDA driver stays off.
// [RQ5] Ignore the bus until a START; STARTs during power-up are dropped.
// [RQ6] STOP after a read or write returns the interface to idle.
// [RQ7] Address is 1 plus three two-bit strap codes; 55 valid, rest reserved.
// [RQ8] Address byte LSB: 1 selects read, 0 selects write.
// [RQ9] After eight address bits compare with own address; acknowledge on match.
// [RQ10] Register address byte follows; pointer resets to 00h.
// [RQ11] Random read repeats the same slave address in both phases.
// [RQ12] Write: address, register, high byte, low byte, each acknowledged, STOP.
// [RQ13] Read: address-write, register, repeated START, address-read, all acknowledged.
// [RQ14] Second data byte only after master ack; master nacks it then STOPs.
// [RQ15] Read pointer loads from register byte, advances once per byte pair.
// [RQ16] Writes chained by repeated STARTs take effect only at final STOP.
// [RQ17] Master should not read back through the group mechanism.
// [RQ18] Master code 0000 1xxx enters high-speed mode for following transfers.
// [RQ19] High-speed mode ends at STOP, survives repeated STARTs.
// [RQ20] As SMBus the master clocks the bus at 100kHz.
// [RQ21] On address mismatch keep SDA released, no ack, skip until next START.
`timescale 1ns/1ps
`default_nettype none
module pmi_slave (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial clock pin, also the link clock
  input  wire logic       link_scl,
  // Serial data pin
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Address strap sensing codes
  input  wire logic [1:0] addr_strap_pin_low,
  input  wire logic [1:0] addr_strap_pin_mid,
  input  wire logic [1:0] addr_strap_pin_high,
  // Register file read port
  output logic      [7:0] rd_addr,
  input  wire logic [15:0] rd_data,
  // Register file write port
  output logic            wr_valid,
  output logic      [7:0] wr_addr,
  output logic      [15:0] wr_data,
  // Status
  output logic            hs_mode,
  output logic            addr_valid
);
  import pmi_pkg::*;

  localparam logic [PU_CNT_W-1:0] PU_LAST = PU_CNT_W'(PU_CYCLES - 1);
  localparam int SYNC_W = 10;

  // ==========================================================================
  // Decoding helpers
  function automatic logic [6:0] strap_addr(input logic [1:0] hi,
                                            input logic [1:0] mid,
                                            input logic [1:0] lo);
    strap_addr = {ADDR_LEAD, hi, mid, lo};
  endfunction : strap_addr

  function automatic logic strap_reserved(input logic [1:0] hi,
                                          input logic [1:0] mid,
                                          input logic [1:0] lo);
    strap_reserved = ((hi == STRAP_SCL) && (mid == STRAP_SDA || mid == STRAP_SCL)) ||
                     ((hi == STRAP_SDA) && (mid == STRAP_GND) && (lo == STRAP_RAIL));
  endfunction : strap_reserved

  function automatic logic is_mcode(input logic [7:0] b);
    is_mcode = (b[7:3] == MCODE_PREFIX);
  endfunction : is_mcode

  // ==========================================================================
  // Crossing from the pins and the link-clock capture
  logic              cap_bit;
  logic              cap_tgl;
  logic [SYNC_W-1:0] sync_q;
  logic              scl_s;
  logic              sda_s;
  logic              tgl_s;
  logic              bit_s;
  logic [1:0]        strap_lo_s;
  logic [1:0]        strap_mid_s;
  logic [1:0]        strap_hi_s;

  pmi_scl_capture u_cap (
    .link_scl (link_scl),
    .rst      (rst),
    .sda_in   (sda_in),
    .bit_val  (cap_bit),
    .bit_tgl  (cap_tgl)
  );

  pmi_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({link_scl, sda_in, cap_tgl, cap_bit,
           addr_strap_pin_high, addr_strap_pin_mid, addr_strap_pin_low}),
    .q   (sync_q)
  );

  assign {scl_s, sda_s, tgl_s, bit_s, strap_hi_s, strap_mid_s, strap_lo_s} = sync_q;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [PU_CNT_W-1:0] pu_cnt;
    logic                ready;
    logic [6:0]          own_addr;
    logic                addr_ok;
    logic                scl_d;
    logic                sda_d;
    logic                tgl_prev;
    logic                bit_ev;
    logic                fall_ev;
    pmi_state_t          st;
    logic [3:0]          bitn;
    logic [7:0]          shreg;
    logic [7:0]          txsh;
    logic [7:0]          txlo;
    logic                txld;
    logic                tx_second;
    logic                mack;
    logic [1:0]          wcnt;
    logic                pend;
    logic [7:0]          wptr;
    logic [15:0]         wdata;
    logic [7:0]          ptr;
    logic                wr_valid;
    logic [7:0]          wr_addr;
    logic [15:0]         wr_data;
    logic                hs_mode;
    logic                sda_oe;
    logic                sda_out;
  } pmi_slave_t;

  pmi_slave_t r;
  pmi_slave_t next_r;

  // ==========================================================================
  // Protocol engine
  always_comb begin
    logic start_cond;
    logic stop_cond;
    next_r          = r;
    start_cond      = scl_s & r.sda_d & ~sda_s;   // see [RQ3]
    stop_cond       = scl_s & ~r.sda_d & sda_s;   // see [RQ3]
    next_r.wr_valid = 1'h0;
    next_r.scl_d    = scl_s;
    next_r.sda_d    = sda_s;
    next_r.tgl_prev = tgl_s;
    // Extra stage on both events keeps bit and fall in pin order
    next_r.bit_ev   = tgl_s ^ r.tgl_prev;
    next_r.fall_ev  = r.scl_d & ~scl_s;

    if (!r.ready) begin
      // Quiet time: bus ignored, driver off, straps settle
      next_r.sda_oe = 1'h0;   // see [RQ4]
      if (r.pu_cnt == PU_LAST) begin
        next_r.ready    = 1'h1;   // see [RQ5]
        next_r.own_addr = strap_addr(strap_hi_s, strap_mid_s, strap_lo_s);   // see [RQ7]
        next_r.addr_ok  = ~strap_reserved(strap_hi_s, strap_mid_s, strap_lo_s);   // see [RQ7]
      end else begin
        next_r.pu_cnt = r.pu_cnt + PU_CNT_W'(1);
      end
    end else if (stop_cond) begin
      // Deferred write lands here, also for chained group packets
      if (r.pend) begin
        next_r.wr_valid = 1'h1;   // see [RQ16]
        next_r.wr_addr  = r.wptr;
        next_r.wr_data  = r.wdata;
      end
      next_r.pend    = 1'h0;
      next_r.hs_mode = 1'h0;   // see [RQ19]
      next_r.st      = ST_IDLE;   // see [RQ6]
      next_r.sda_oe  = 1'h0;
      next_r.bitn    = 4'h0;
    end else if (start_cond) begin
      // Repeated START keeps hs_mode and any pending write
      next_r.st     = ST_ADDR;   // see [RQ5]
      next_r.bitn   = 4'h0;
      next_r.sda_oe = 1'h0;
      next_r.txld   = 1'h0;
    end else if (r.bit_ev) begin
      unique case (r.st)
        ST_ADDR, ST_REG, ST_DATA: begin
          if (r.bitn < BIT_LAST) begin
            next_r.shreg = {r.shreg[6:0], bit_s};   // see [RQ2]
            next_r.bitn  = r.bitn + BIT_STEP;
          end else if (r.bitn == ACK_SLOT) begin
            next_r.bitn = ACK_DONE;
          end
        end
        ST_TX: begin
          if (r.bitn < BIT_LAST) begin
            next_r.txsh = {r.txsh[6:0], 1'h0};
            next_r.bitn = r.bitn + BIT_STEP;
          end else if (r.bitn == ACK_SLOT) begin
            next_r.bitn = ACK_DONE;
            if (!r.txld) begin
              next_r.mack = ~bit_s;   // see [RQ14]
              if (r.tx_second) begin
                next_r.ptr = r.ptr + PTR_STEP;   // see [RQ15]
              end
            end
          end
        end
        ST_IDLE, ST_SKIP: begin
          next_r.bitn = 4'h0;
        end
      endcase
    end else if (r.fall_ev) begin
      // SDA only moves right after SCL has fallen
      unique case (r.st)
        ST_ADDR: begin
          if (r.bitn == BIT_LAST) begin
            if (is_mcode(r.shreg)) begin
              // Master code is never acknowledged
              next_r.hs_mode = 1'h1;   // see [RQ18]
              next_r.st      = ST_SKIP;
              next_r.bitn    = 4'h0;
            end else if (r.addr_ok && r.shreg[7:1] == r.own_addr) begin
              next_r.sda_oe = 1'h1;   // see [RQ9]
              next_r.bitn   = ACK_SLOT;
              if (r.shreg[0] == DIR_READ) begin
                next_r.st   = ST_TX;   // see [RQ8]
                next_r.txld = 1'h1;
              end else begin
                next_r.st = ST_REG;   // see [RQ13]
              end
            end else begin
              next_r.sda_oe = 1'h0;   // see [RQ21]
              next_r.st     = ST_SKIP;
              next_r.bitn   = 4'h0;
            end
          end else if (r.bitn == ACK_DONE) begin
            next_r.sda_oe = 1'h0;
            next_r.bitn   = 4'h0;
          end
        end
        ST_REG: begin
          if (r.bitn == BIT_LAST) begin
            next_r.ptr    = r.shreg;   // see [RQ10]
            next_r.wcnt   = WCNT_HI;
            next_r.sda_oe = 1'h1;
            next_r.bitn   = ACK_SLOT;
            next_r.st     = ST_DATA;
          end else if (r.bitn == ACK_DONE) begin
            next_r.sda_oe = 1'h0;
            next_r.bitn   = 4'h0;
          end
        end
        ST_DATA: begin
          if (r.bitn == BIT_LAST) begin
            unique case (r.wcnt)
              WCNT_HI: begin
                next_r.wdata[15:8] = r.shreg;   // see [RQ12]
                next_r.wcnt        = WCNT_LO;
                next_r.sda_oe      = 1'h1;
                next_r.bitn        = ACK_SLOT;
              end
              WCNT_LO: begin
                next_r.wdata[7:0] = r.shreg;   // see [RQ12]
                next_r.wptr       = r.ptr;
                next_r.pend       = 1'h1;   // see [RQ16]
                next_r.wcnt       = WCNT_FULL;
                next_r.sda_oe     = 1'h1;
                next_r.bitn       = ACK_SLOT;
              end
              default: begin
                // A third byte breaks the two-byte format
                next_r.st   = ST_SKIP;   // see [RQ2]
                next_r.bitn = 4'h0;
              end
            endcase
          end else if (r.bitn == ACK_DONE) begin
            next_r.sda_oe = 1'h0;
            next_r.bitn   = 4'h0;
          end
        end
        ST_TX: begin
          if (r.bitn < BIT_LAST) begin
            next_r.sda_oe = ~r.txsh[7];   // see [RQ2]
          end else if (r.bitn == BIT_LAST) begin
            next_r.sda_oe = 1'h0;
            next_r.bitn   = ACK_SLOT;
          end else if (r.bitn == ACK_DONE) begin
            next_r.bitn = 4'h0;
            if (r.txld) begin
              next_r.txld      = 1'h0;
              next_r.tx_second = 1'h0;
              next_r.txsh      = rd_data[15:8];   // see [RQ15]
              next_r.txlo      = rd_data[7:0];
              next_r.sda_oe    = ~rd_data[15];
            end else if (r.mack && !r.tx_second) begin
              next_r.tx_second = 1'h1;   // see [RQ14]
              next_r.txsh      = r.txlo;
              next_r.sda_oe    = ~r.txlo[7];
            end else begin
              // Nack or pair done: release and wait for STOP
              next_r.sda_oe = 1'h0;   // see [RQ14]
              next_r.st     = ST_SKIP;
            end
          end
        end
        ST_IDLE, ST_SKIP: begin
          next_r.sda_oe = 1'h0;   // see [RQ21]
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      r         <= '0;
      r.st      <= ST_IDLE;
      r.ptr     <= PTR_RESET;   // see [RQ10]
      r.sda_oe  <= 1'h0;   // see [RQ4]
      r.sda_out <= 1'h0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs, all straight from state
  assign sda_out    = r.sda_out;
  assign sda_oe     = r.sda_oe;
  assign rd_addr    = r.ptr;
  assign wr_valid   = r.wr_valid;
  assign wr_addr    = r.wr_addr;
  assign wr_data    = r.wr_data;
  assign hs_mode    = r.hs_mode;
  assign addr_valid = r.addr_ok;

endmodule : pmi_slave
`default_nettype wire

// ### verif/pmi_slave_chk.sv
// Concurrent checks on the slave's pins and write port
`timescale 1ns/1ps
`default_nettype none
module pmi_slave_chk
  import pmi_pkg::*;
(
  // Clock, reset and bus clock
  input wire logic clk,
  input wire logic rst,
  input wire logic link_scl,
  // Data line
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Write port and status
  input wire logic wr_valid,
  input wire logic hs_mode,
  input wire logic addr_valid
);
  // ==========================================================================
  // Cycles since reset release, saturating
  logic [5:0] pu_cnt;

  always_ff @(posedge clk) begin
    if (rst)
      pu_cnt <= 6'h00;
    else if (pu_cnt != 6'h3f)
      pu_cnt <= pu_cnt + 6'h01;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // Bus events
  sequence s_stop;
    link_scl && $past(link_scl) && $rose(sda_in);
  endsequence
  sequence s_idle;
    link_scl && sda_in;
  endsequence

  // ==========================================================================
  // Properties
  property p_drv_low;
    sda_out == 1'b0;
  endproperty
  property p_pu_quiet;
    pu_cnt < PU_CYCLES |-> !sda_oe;
  endproperty
  property p_oe_scl_low;
    link_scl && $past(link_scl) |-> $stable(sda_oe);
  endproperty
  property p_wr_idle;
    wr_valid |-> s_idle;
  endproperty
  property p_wr_pulse;
    wr_valid |=> !wr_valid;
  endproperty
  property p_hs_end;
    s_stop |-> ##[1:8] !hs_mode;
  endproperty
  property p_hs_nak;
    $rose(hs_mode) |-> !sda_oe;
  endproperty
  property p_resv;
    !addr_valid |-> !sda_oe;
  endproperty
  property p_wr_addr;
    wr_valid |-> addr_valid;
  endproperty

  a_drv_low: assert property (p_drv_low)
    else $error("sda driven high");
  a_pu_quiet: assert property (p_pu_quiet)
    else $error("sda pulled during power-up");
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("sda changed while scl high");
  a_wr_idle: assert property (p_wr_idle)
    else $error("write applied before stop");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  a_hs_end: assert property (p_hs_end)
    else $error("high-speed mode kept after stop");
  a_hs_nak: assert property (p_hs_nak)
    else $error("master code acknowledged");
  a_resv: assert property (p_resv)
    else $error("reserved straps still answered");
  a_wr_addr: assert property (p_wr_addr)
    else $error("write without valid address");
endmodule : pmi_slave_chk

bind pmi_slave pmi_slave_chk u_chk (.clk(clk), .rst(rst), .link_scl(link_scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid),
  .hs_mode(hs_mode), .addr_valid(addr_valid));
`default_nettype wire

// ### verif/pmi_bus_master.sv
// Behavioural two-wire bus master driving the slave's pins
`timescale 1ns/1ps
`default_nettype none
module pmi_bus_master (
  // Resolved data line
  input  wire logic sda,
  // Clock and data pull-down
  output var logic  scl,
  output var logic  sda_pull
);
  int lo_ns = 240;
  int hi_ns = 96;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // ==========================================================================
  // Bit, frame and byte cycles
  task automatic set_rate(input int lo, input int hi);
    lo_ns = lo;
    hi_ns = hi;
  endtask : set_rate

  // Data moves 48 ns after SCL falls so it never reads as START or STOP
  task automatic bit_io(input logic b, output logic s);
    #48;
    sda_pull = !b;
    #(lo_ns - 48);
    scl = 1'b1;
    #(hi_ns / 2);
    s = sda;
    #(hi_ns - hi_ns / 2);
    scl = 1'b0;
  endtask : bit_io

  task automatic pulse();
    scl = 1'b0;
    #(hi_ns);
    scl = 1'b1;
    #(hi_ns);
  endtask : pulse

  // Also a repeated START when SCL is low
  task automatic start();
    if (!scl) begin
      #48;
      sda_pull = 1'b0;
      #(lo_ns - 48);
      scl = 1'b1;
    end
    #(hi_ns);
    sda_pull = 1'b1;
    #(hi_ns);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    #48;
    sda_pull = 1'b1;
    #(lo_ns - 48);
    scl = 1'b1;
    #(hi_ns);
    sda_pull = 1'b0;
    #(hi_ns);
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic ak);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, ak);
  endtask : wbyte

  task automatic rbyte(output logic [7:0] d, input logic nak);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nak, s);
  endtask : rbyte
endmodule : pmi_bus_master
`default_nettype wire

// ### verif/tb_pmi_slave.sv
// Self-checking bench for the two-wire slave against a behavioural master
`timescale 1ns/1ps
`default_nettype none
module tb_pmi_slave;
  import pmi_pkg::*;
  localparam logic [6:0] ADR    = 7'h5b;
  localparam logic [5:0] STRAPS = 6'h1b;
  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic [1:0]  st_lo       = 2'h0;
  logic [1:0]  st_mid      = 2'h0;
  logic [1:0]  st_hi       = 2'h0;
  logic [15:0] rd_data     = 16'h0000;
  logic        scl;
  logic        pull;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  logic [7:0]  rd_addr;
  logic        wr_valid;
  logic [7:0]  wr_addr;
  logic [15:0] wr_data;
  logic        hs_mode;
  logic        addr_valid;
  logic [7:0]  wa;
  logic [15:0] wd;
  int          wr_cnt      = 0;
  int          miscompares = 0;
  int          cmp_count   = 0;

  always #12.5 clk = ~clk;
  // Open-drain line with pull-up
  assign sda = !(pull || (sda_oe && !sda_out));

  pmi_bus_master mst (.sda(sda), .scl(scl), .sda_pull(pull));
  pmi_slave uut (.clk(clk), .rst(rst), .link_scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_pin_low(st_lo), .addr_strap_pin_mid(st_mid),
    .addr_strap_pin_high(st_hi), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .hs_mode(hs_mode),
    .addr_valid(addr_valid));

  function automatic logic [15:0] word_at(input logic [7:0] a);
    return {a ^ 8'ha5, a};
  endfunction : word_at

  // ==========================================================================
  // Register file and write capture
  always @(posedge clk) begin
    rd_data <= word_at(rd_addr);
    if (wr_valid === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wa <= wr_addr;
      wd <= wr_data;
    end
  end

  // ==========================================================================
  // Common tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // SCL pulses in reset so the capture flops start defined
  task automatic do_reset(input logic [5:0] s);
    @(posedge clk);
    rst <= 1'b1;
    {st_hi, st_mid, st_lo} <= s;
    mst.pulse();
    mst.pulse();
    @(posedge clk);
    rst <= 1'b0;
    // Capture drops two SCL rises after release; spend them in quiet time
    mst.pulse();
    mst.pulse();
  endtask : do_reset

  task automatic wait_wr(input int n);
    for (int i = 0; i < 40 && wr_cnt != n; i++)
      @(posedge clk);
    check(wr_cnt, n);
    if (wr_cnt != n)
      print_verdict();
  endtask : wait_wr

  task automatic write_pkt(input logic [6:0] a, input logic [7:0] r, input logic [15:0] d,
                           input logic nak);
    logic ak [4];
    mst.start();
    mst.wbyte({a, 1'b0}, ak[0]);
    mst.wbyte(r, ak[1]);
    mst.wbyte(d[15:8], ak[2]);
    mst.wbyte(d[7:0], ak[3]);
    foreach (ak[i]) check(ak[i], nak);
  endtask : write_pkt

  task automatic set_ptr(input logic [7:0] r);
    logic ak [2];
    mst.start();
    mst.wbyte({ADR, 1'b0}, ak[0]);
    mst.wbyte(r, ak[1]);
    foreach (ak[i]) check(ak[i], 1'b0);
  endtask : set_ptr

  // Same slave address as the dummy write
  task automatic read_pair(input logic nak1, output logic [15:0] d);
    logic ak;
    mst.start();
    mst.wbyte({ADR, 1'b1}, ak);
    check(ak, 1'b0);
    mst.rbyte(d[15:8], nak1);
    if (!nak1)
      mst.rbyte(d[7:0], 1'b1);
    // Reads always close with STOP, never chained into a group
    mst.stop();
  endtask : read_pair

  // ==========================================================================
  // Scenarios
  task automatic t_powerup();
    logic        ak;
    logic [15:0] d;
    do_reset(STRAPS);
    mst.start();
    mst.wbyte({ADR, 1'b0}, ak);
    check(ak, 1'b1);
    mst.stop();
    read_pair(1'b0, d);
    check(d, word_at(8'h00));
  endtask : t_powerup

  task automatic t_write();
    mst.set_rate(5040, 4960);
    write_pkt(ADR, 8'h3c, 16'ha51e, 1'b0);
    mst.stop();
    wait_wr(1);
    check(wa, 8'h3c);
    check(wd, 16'ha51e);
    mst.set_rate(240, 96);
  endtask : t_write

  task automatic t_group();
    logic ak;
    write_pkt(ADR, 8'h07, 16'h1234, 1'b0);
    // Third data byte is refused
    mst.wbyte(8'h55, ak);
    check(ak, 1'b1);
    write_pkt(ADR ^ 7'h01, 8'h08, 16'hffff, 1'b1);
    check(wr_cnt, 1);
    mst.stop();
    wait_wr(2);
    check(wa, 8'h07);
    check(wd, 16'h1234);
  endtask : t_group

  task automatic t_read();
    logic [15:0] d;
    set_ptr(8'h21);
    read_pair(1'b0, d);
    check(d, word_at(8'h21));
    read_pair(1'b0, d);
    check(d, word_at(8'h22));
    read_pair(1'b1, d);
    check(d[15:8], word_at(8'h23) >> 8);
    read_pair(1'b0, d);
    check(d, word_at(8'h23));
  endtask : t_read

  task automatic t_hs();
    logic        ak;
    logic [15:0] d;
    mst.set_rate(1680, 960);
    mst.start();
    mst.wbyte(8'h0d, ak);
    check(ak, 1'b1);
    check(hs_mode, 1'b1);
    mst.set_rate(240, 96);
    write_pkt(ADR, 8'h44, 16'h0f0f, 1'b0);
    write_pkt(ADR ^ 7'h02, 8'h45, 16'hf0f0, 1'b1);
    check(hs_mode, 1'b1);
    mst.stop();
    wait_wr(3);
    check(wa, 8'h44);
    read_pair(1'b0, d);
    check(d, word_at(8'h44));
    check(hs_mode, 1'b0);
  endtask : t_hs

  task automatic t_straps();
    logic [5:0] tbl [4] = '{6'h00, 6'h30, 6'h3f, 6'h21};
    int         n;
    n = wr_cnt;
    foreach (tbl[i]) begin
      do_reset(tbl[i]);
      repeat (PU_CYCLES + 8) @(posedge clk);
      check(addr_valid, i < 2);
      write_pkt({1'b1, tbl[i]}, 8'h66, 16'h1357, i >= 2);
      mst.stop();
      if (i < 2)
        n++;
      wait_wr(n);
    end
  endtask : t_straps

  initial begin
    t_powerup();
    t_write();
    t_group();
    t_read();
    t_hs();
    t_straps();
    print_verdict();
  end
endmodule : tb_pmi_slave
`default_nettype wire
